/* File: pin_select_pkg.sv */
// shared constants for the port / analog pin function select block
package pin_select_pkg;

   // bus geometry
   localparam int ADDR_W = 10;
   localparam int DATA_W = 32;
   localparam int IDX_W  = 8;

   // pin and channel counts
   localparam int NIB_W    = 4;
   localparam int PIN_CNT  = 16;
   localparam int CHAN_CNT = 12;

   // register indices, byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_PORT_MODE_A   = 8'h04;
   localparam logic [IDX_W-1:0] IDX_SERIAL_MODE   = 8'h05;
   localparam logic [IDX_W-1:0] IDX_EXTRA_CTRL    = 8'h0C;
   localparam logic [IDX_W-1:0] IDX_ANALOG_SEL_A  = 8'h19;
   localparam logic [IDX_W-1:0] IDX_ANALOG_SEL_B  = 8'h1A;
   localparam logic [IDX_W-1:0] IDX_DIR_BASE      = 8'h30;
   localparam logic [IDX_W-1:0] IDX_LATCH_BASE    = 8'h40;
   localparam logic [IDX_W-1:0] IDX_PIN_LEVEL     = 8'h50;
   localparam logic [IDX_W-1:0] IDX_PIN_DRIVE     = 8'h51;

   // index steps from a base to the port 3, 4 and 5 nibbles
   localparam logic [IDX_W-1:0] STEP_PORT3 = 8'h03;
   localparam logic [IDX_W-1:0] STEP_PORT4 = 8'h04;
   localparam logic [IDX_W-1:0] STEP_PORT5 = 8'h05;

   // field positions
   localparam int SO_SEL_BIT     = 0;
   localparam int SI_SEL_BIT     = 1;
   localparam int TOC_SEL_BIT    = 2;
   localparam int SCK_SEL_BIT    = 3;
   localparam int OPENDRAIN_BIT  = 2;
   localparam int PULLUP_BIT     = 3;
   localparam int P4_GROUP_BIT   = 1;
   localparam int P5_GROUP_BIT   = 2;

   // pin positions within the flat 16-pin vector
   localparam int PIN_SCK = 0;
   localparam int PIN_SI  = 1;
   localparam int PIN_SO  = 2;
   localparam int PIN_TOC = 3;

   // reset values
   localparam logic [NIB_W-1:0] LATCH_RST  = 4'hF;
   localparam logic [NIB_W-1:0] DIR_RST    = 4'h0;
   localparam logic [NIB_W-1:0] SEL_RST    = 4'h0;
   localparam logic [2:0]       SEL_B_RST  = 3'h0;
   localparam logic [NIB_W-1:0] CTRL_RST   = 4'h0;

endpackage

/* File: port_analog_pin_function_select.sv */
// pin function select for port groups 0 and 3 to 5 with Avalon-MM slave
module port_analog_pin_function_select
   import pin_select_pkg::*;
(
   // clock and reset
   input  wire logic                clk_sys,
   input  wire logic                sys_rst,

   // avalon-mm register slave
   input  wire logic [ADDR_W-1:0]   avs_address,
   input  wire logic                avs_read,
   input  wire logic                avs_write,
   input  wire logic [DATA_W-1:0]   avs_writedata,
   input  wire logic [3:0]          avs_byteenable,
   output logic      [DATA_W-1:0]   avs_readdata,
   output logic                     avs_waitrequest,

   // shared pins: bit 4*g+n is group g (ports 0,3,4,5) pin n
   input  wire logic [PIN_CNT-1:0]  pin_in,
   output logic      [PIN_CNT-1:0]  pin_out,
   output logic      [PIN_CNT-1:0]  pin_oe_n,
   output logic      [PIN_CNT-1:0]  pin_pullup_on,

   // serial interface side
   input  wire logic                sck_out,
   input  wire logic                sck_drive,
   output logic                     sck_in,
   output logic                     serial_in_data,
   input  wire logic                serial_out_data,

   // timer C side
   input  wire logic                timer_c_output_pin,

   // analog converter side: channel inputs connected to pins
   output logic      [CHAN_CNT-1:0] adc_channel_pin
);

   // group decode: returns {hit, group} for ports 0,3,4,5 at a base
   function automatic logic [2:0] group_hit(
      input logic [IDX_W-1:0] idx,
      input logic [IDX_W-1:0] base
   );
      logic [2:0] res;
      res = 3'h0;
      if (idx == base) begin
         res = 3'h4;
      end else if (idx == base + STEP_PORT3) begin
         res = 3'h5;
      end else if (idx == base + STEP_PORT4) begin
         res = 3'h6;
      end else if (idx == base + STEP_PORT5) begin
         res = 3'h7;
      end
      return res;
   endfunction

   // software-visible state, held as internal copies
   logic [NIB_W-1:0]   port_mode_reg_a_reg;
   logic [NIB_W-1:0]   serial_mode_reg;
   logic [NIB_W-1:0]   extra_control_reg;
   logic [NIB_W-1:0]   analog_pin_select_a_reg;
   logic [2:0]         analog_pin_select_b_reg;
   logic [PIN_CNT-1:0] port_direction_bit_reg;
   logic [PIN_CNT-1:0] port_output_latch_reg;

   // bus handshake state
   logic               ack_reg;
   logic [DATA_W-1:0]  rdata_reg;
   logic               req;
   logic               wr_en;
   logic [IDX_W-1:0]   idx;
   logic [2:0]         dir_hit;
   logic [2:0]         latch_hit;
   logic [NIB_W-1:0]   wnib;

   // per-register write strobes
   logic               wr_mode_a;
   logic               wr_serial_mode;
   logic               wr_extra_ctrl;
   logic               wr_sel_a;
   logic               wr_sel_b;
   logic               wr_dir;
   logic               wr_latch;

   // pin mux results
   logic [PIN_CNT-1:0] analog_mask;
   logic [PIN_CNT-1:0] periph_drive;
   logic [PIN_CNT-1:0] periph_value;
   logic [PIN_CNT-1:0] drive_next;
   logic [PIN_CNT-1:0] value_next;
   logic [PIN_CNT-1:0] pullup_next;
   logic [DATA_W-1:0]  rdata_next;

   // output flops
   logic [PIN_CNT-1:0]  pin_out_reg;
   logic [PIN_CNT-1:0]  pin_oe_n_reg;
   logic [PIN_CNT-1:0]  pin_pullup_reg;
   logic [CHAN_CNT-1:0] adc_channel_reg;
   logic                sck_in_reg;
   logic                serial_in_reg;

   // address and write decode
   assign req       = avs_read | avs_write;
   assign idx       = avs_address[ADDR_W-1:2];
   assign wnib      = avs_writedata[NIB_W-1:0];
   assign dir_hit   = group_hit(idx, IDX_DIR_BASE);
   assign latch_hit = group_hit(idx, IDX_LATCH_BASE);
   assign wr_en     = avs_write & ack_reg & avs_byteenable[0];

   // per-register write strobes, only in the answer cycle
   assign wr_mode_a      = wr_en & (idx == IDX_PORT_MODE_A);
   assign wr_serial_mode = wr_en & (idx == IDX_SERIAL_MODE);
   assign wr_extra_ctrl  = wr_en & (idx == IDX_EXTRA_CTRL);
   assign wr_sel_a       = wr_en & (idx == IDX_ANALOG_SEL_A);
   assign wr_sel_b       = wr_en & (idx == IDX_ANALOG_SEL_B);
   assign wr_dir         = wr_en & dir_hit[2];
   assign wr_latch       = wr_en & latch_hit[2];

   // one wait state on every access, then the answer
   assign avs_waitrequest = req & ~ack_reg;
   assign avs_readdata    = rdata_reg;

   // handshake: ack for exactly one cycle per request
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= req & ~ack_reg;
      end
   end

   // read mux; select registers are write-only and read zero
   always_comb begin
      rdata_next = '0;
      if (idx == IDX_PIN_LEVEL) begin
         rdata_next[PIN_CNT-1:0] = pin_in;
      end else if (idx == IDX_PIN_DRIVE) begin
         rdata_next[PIN_CNT-1:0] = ~pin_oe_n_reg;
      end
   end

   // read data captured in the wait cycle, held for the answer
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         rdata_reg <= '0;
      end else if (avs_read & ~ack_reg) begin
         rdata_reg <= rdata_next;
      end
   end

   // port mode register A: serial out, serial in, timer C select
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         port_mode_reg_a_reg <= SEL_RST;
      end else if (wr_mode_a) begin
         port_mode_reg_a_reg <= wnib;
      end
   end

   // serial mode register, only the clock pin select acts here
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         serial_mode_reg <= SEL_RST;
      end else if (wr_serial_mode) begin
         serial_mode_reg <= wnib;
      end
   end

   // extra control: open-drain and global pull-up bits
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         extra_control_reg <= CTRL_RST;
      end else if (wr_extra_ctrl) begin
         extra_control_reg <= wnib;
      end
   end

   // first analog select, one bit per port 3 pin
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         analog_pin_select_a_reg <= SEL_RST;
      end else if (wr_sel_a) begin
         analog_pin_select_a_reg <= wnib;
      end
   end

   // second analog select, group bits for ports 4 and 5
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         analog_pin_select_b_reg <= SEL_B_RST;
      end else if (wr_sel_b) begin
         analog_pin_select_b_reg <= wnib[2:0];
      end
   end

   // direction bits, one nibble per port group
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         port_direction_bit_reg <= {4{DIR_RST}};
      end else if (wr_dir) begin
         port_direction_bit_reg[dir_hit[1:0]*NIB_W +: NIB_W] <= wnib;
      end
   end

   // output latches, one nibble per port group
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         port_output_latch_reg <= {4{LATCH_RST}};
      end else if (wr_latch) begin
         port_output_latch_reg[latch_hit[1:0]*NIB_W +: NIB_W] <= wnib;
      end
   end

   // analog select mask over the flat pin vector
   assign analog_mask = {
      {NIB_W{analog_pin_select_b_reg[P5_GROUP_BIT]}},
      {NIB_W{analog_pin_select_b_reg[P4_GROUP_BIT]}},
      analog_pin_select_a_reg,
      {NIB_W{1'b0}}
   };

   // pull-up follows enable and latch, blind to analog select
   assign pullup_next = {PIN_CNT{extra_control_reg[PULLUP_BIT]}}
                      & port_output_latch_reg;

   // pin mux: peripheral overrides on top of direction and latch
   always_comb begin
      periph_drive = port_direction_bit_reg;
      periph_value = port_output_latch_reg;
      // serial clock pin follows the serial block's own direction
      if (serial_mode_reg[SCK_SEL_BIT]) begin
         periph_drive[PIN_SCK] = sck_drive;
         periph_value[PIN_SCK] = sck_out;
      end
      // serial data in pin never drives
      if (port_mode_reg_a_reg[SI_SEL_BIT]) begin
         periph_drive[PIN_SI] = 1'b0;
         periph_value[PIN_SI] = 1'b0;
      end
      // serial data out pin drives here; open drain below can release a high level
      if (port_mode_reg_a_reg[SO_SEL_BIT]) begin
         periph_drive[PIN_SO] = 1'b1;
         periph_value[PIN_SO] = serial_out_data;
      end
      // timer C output pin always drives
      if (port_mode_reg_a_reg[TOC_SEL_BIT]) begin
         periph_drive[PIN_TOC] = 1'b1;
         periph_value[PIN_TOC] = timer_c_output_pin;
      end
   end

   // analog float and open drain gating after the overrides
   always_comb begin
      drive_next = periph_drive & ~analog_mask;
      value_next = periph_value;
      // open drain: a high level on the serial out pin is released, never pushed
      if (extra_control_reg[OPENDRAIN_BIT] && periph_value[PIN_SO]) begin
         drive_next[PIN_SO] = 1'b0;
      end
   end

   // registered pin output values
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         pin_out_reg <= {4{LATCH_RST}};
      end else begin
         pin_out_reg <= value_next;
      end
   end

   // registered active-low output enables
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         pin_oe_n_reg <= {PIN_CNT{1'b1}};
      end else begin
         pin_oe_n_reg <= ~drive_next;
      end
   end

   // registered pull-up controls
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         pin_pullup_reg <= '0;
      end else begin
         pin_pullup_reg <= pullup_next;
      end
   end

   // registered converter channel connections
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         adc_channel_reg <= '0;
      end else begin
         adc_channel_reg <= analog_mask[PIN_CNT-1:NIB_W];
      end
   end

   // serial clock level to the serial block, idle high unselected
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         sck_in_reg <= 1'b1;
      end else begin
         sck_in_reg <= serial_mode_reg[SCK_SEL_BIT]
                     ? pin_in[PIN_SCK] : 1'b1;
      end
   end

   // serial data level to the serial block, idle high unselected
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         serial_in_reg <= 1'b1;
      end else begin
         serial_in_reg <= port_mode_reg_a_reg[SI_SEL_BIT]
                        ? pin_in[PIN_SI] : 1'b1;
      end
   end

   // outputs
   assign pin_out         = pin_out_reg;
   assign pin_oe_n        = pin_oe_n_reg;
   assign pin_pullup_on   = pin_pullup_reg;
   assign adc_channel_pin = adc_channel_reg;
   assign sck_in          = sck_in_reg;
   assign serial_in_data  = serial_in_reg;

endmodule

/* File: pin_select_chk.sv */
// concurrent checks on the pin function select block ports
module pin_select_chk
   import pin_select_pkg::*;
(
   // clock and reset
   input  wire logic                clk_sys,
   input  wire logic                sys_rst,
   // bus handshake
   input  wire logic                avs_read,
   input  wire logic                avs_write,
   input  wire logic                avs_waitrequest,
   // pin side
   input  wire logic [PIN_CNT-1:0]  pin_out,
   input  wire logic [PIN_CNT-1:0]  pin_oe_n,
   input  wire logic [PIN_CNT-1:0]  pin_pullup_on,
   input  wire logic [CHAN_CNT-1:0] adc_channel_pin
);
   timeunit 1ns;
   timeprecision 1ns;

   // one clock domain, checks paused in reset except the reset pin check
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   a_wait_one_state: assert property (
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("bus request waited more than one cycle");
   a_idle_no_wait: assert property (
      !(avs_read || avs_write) |-> !avs_waitrequest)
      else $error("waitrequest high without a request");
   a_reset_pins: assert property (disable iff (1'b0)
      sys_rst |=> (&pin_out) && (&pin_oe_n) && pin_pullup_on == '0
      && adc_channel_pin == '0) else $error("pins not at reset state");
   a_analog_float: assert property (
      (adc_channel_pin & ~pin_oe_n[15:4]) == '0)
      else $error("analog pin still driven");
   a_port4_group: assert property (
      adc_channel_pin[7:4] == 4'h0 || adc_channel_pin[7:4] == 4'hF)
      else $error("port 4 channels not switched as a group");
   a_port5_group: assert property (
      adc_channel_pin[11:8] == 4'h0 || adc_channel_pin[11:8] == 4'hF)
      else $error("port 5 channels not switched as a group");
   a_adc_after_write: assert property (
      $changed(adc_channel_pin) |-> $past(avs_write && !avs_waitrequest, 2))
      else $error("channel connect changed without a write");
   a_oe_after_write: assert property (
      $changed(pin_oe_n[15:4]) |-> $past(avs_write && !avs_waitrequest, 2))
      else $error("port enable changed without a write");

   // main scenarios reached
   c_write_done: cover property (avs_write && !avs_waitrequest);
   c_port5_analog: cover property (adc_channel_pin[11:8] == 4'hF);
   c_pullup_analog: cover property (|(adc_channel_pin[3:0] & pin_pullup_on[7:4]));
endmodule

bind port_analog_pin_function_select pin_select_chk pin_select_chk_inst (
   .clk_sys(clk_sys), .sys_rst(sys_rst), .avs_read(avs_read),
   .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
   .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_pullup_on(pin_pullup_on),
   .adc_channel_pin(adc_channel_pin));

/* File: board_pins.sv */
// board model: pin levels seen by the block
module board_pins
   import pin_select_pkg::*;
(
   // block pin side
   input  wire logic [PIN_CNT-1:0] pin_out,
   input  wire logic [PIN_CNT-1:0] pin_oe_n,
   input  wire logic [PIN_CNT-1:0] pin_pullup_on,
   // external sources when nothing drives or pulls
   input  wire logic [PIN_CNT-1:0] ext_lvl,
   output logic      [PIN_CNT-1:0] pin_in
);
   timeunit 1ns;
   timeprecision 1ns;

   // driven pin reads back, pulled pin reads high, else board level
   always_comb begin
      for (int i = 0; i < PIN_CNT; i++) begin
         pin_in[i] = !pin_oe_n[i] ? pin_out[i] :
                     pin_pullup_on[i] ? 1'b1 : ext_lvl[i];
      end
   end
endmodule

/* File: port_analog_pin_function_select_bench.sv */
// register-level bench for the pin function select block
module port_analog_pin_function_select_bench;
   import pin_select_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;

   logic                clk_sys = 1'b0;
   logic                sys_rst = 1'b1;
   logic [ADDR_W-1:0]   avs_address = '0;
   logic                avs_read = 1'b0;
   logic                avs_write = 1'b0;
   logic [DATA_W-1:0]   avs_writedata = '0;
   logic [3:0]          avs_byteenable = 4'hF;
   logic [DATA_W-1:0]   avs_readdata, rd;
   logic                avs_waitrequest, sck_in, serial_in_data;
   logic [PIN_CNT-1:0]  pin_in, pin_out, pin_oe_n, pin_pullup_on;
   logic [PIN_CNT-1:0]  ext_lvl = 16'h0000;
   logic                sck_out = 1'b0;
   logic                sck_drive = 1'b0;
   logic                serial_out_data = 1'b1;
   logic                timer_c = 1'b1;
   logic [CHAN_CNT-1:0] adc_channel_pin;
   int                  n_mismatch = 0;
   int                  check_count = 0;

   always #20 clk_sys = ~clk_sys;

   port_analog_pin_function_select port_analog_pin_function_select_inst (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
      .pin_pullup_on(pin_pullup_on), .sck_out(sck_out),
      .sck_drive(sck_drive), .sck_in(sck_in),
      .serial_in_data(serial_in_data), .serial_out_data(serial_out_data),
      .timer_c_output_pin(timer_c), .adc_channel_pin(adc_channel_pin));

   board_pins board_pins_inst (
      .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_pullup_on(pin_pullup_on),
      .ext_lvl(ext_lvl), .pin_in(pin_in));

   // compare one value
   task automatic chk(input string nm, input logic [15:0] e,
                      input logic [15:0] g);
      check_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask

   // hold request until waitrequest is seen low at a rising edge
   task automatic wait_ack();
      do begin
         @(posedge clk_sys);
      end while (avs_waitrequest !== 1'b0);
   endtask

   task automatic bus_w(input logic [IDX_W-1:0] idx, input logic [3:0] d,
                        input logic [3:0] be = 4'hF);
      @(posedge clk_sys);
      avs_address <= {idx, 2'b00};
      avs_writedata <= {28'h0, d};
      avs_byteenable <= be;
      avs_write <= 1'b1;
      wait_ack();
      avs_write <= 1'b0;
   endtask

   task automatic bus_r(input logic [IDX_W-1:0] idx);
      @(posedge clk_sys);
      avs_address <= {idx, 2'b00};
      avs_read <= 1'b1;
      wait_ack();
      rd = avs_readdata;
      avs_read <= 1'b0;
   endtask

   // let pin outputs follow a register change
   task automatic settle();
      repeat (3) @(negedge clk_sys);
   endtask

   task automatic test_done();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // watchdog
   initial begin
      repeat (5000) @(posedge clk_sys);
      n_mismatch++;
      test_done();
   end

   initial begin
      repeat (12) @(posedge clk_sys);
      sys_rst <= 1'b0;
      settle();
      chk("oe_n", 16'hFFFF, pin_oe_n);
      chk("out", 16'hFFFF, pin_out);
      chk("adc", 16'h0000, {4'h0, adc_channel_pin});
      bus_w(IDX_EXTRA_CTRL, 4'h8);
      bus_w(IDX_ANALOG_SEL_A, 4'hF);
      settle();
      chk("pullup", 16'hFFFF, pin_pullup_on);
      chk("adc", 16'h000F, {4'h0, adc_channel_pin});
      bus_r(IDX_ANALOG_SEL_A);
      chk("sel_a read", 16'h0000, rd[15:0]);
      bus_w(IDX_DIR_BASE + STEP_PORT3, 4'hF);
      bus_w(IDX_LATCH_BASE + STEP_PORT3, 4'h5);
      settle();
      chk("oe_n", 16'hFFFF, pin_oe_n);
      bus_w(IDX_ANALOG_SEL_A, 4'h6);
      settle();
      chk("oe_n", 16'hFF6F, pin_oe_n);
      chk("p3 out", 16'h0001, {14'h0, pin_out[7], pin_out[4]});
      chk("pullup", 16'hFF5F, pin_pullup_on);
      bus_w(IDX_LATCH_BASE + STEP_PORT3, 4'h0);
      bus_w(IDX_EXTRA_CTRL, 4'h0);
      bus_w(IDX_ANALOG_SEL_A, 4'hF);
      settle();
      chk("pullup", 16'h0000, pin_pullup_on);
      for (int i = 2; i <= 6; i += 2) begin
         bus_w(IDX_ANALOG_SEL_B, i[3:0]);
         settle();
         chk("adc", {4'h0, {4{i[2]}}, {4{i[1]}}, 4'hF},
             {4'h0, adc_channel_pin});
      end
      bus_w(IDX_ANALOG_SEL_B, 4'h0, 4'h0);
      settle();
      chk("adc", 16'h0FFF, {4'h0, adc_channel_pin});
      bus_r(8'h7F);
      chk("unmapped", 16'h0000, rd[15:0]);
      bus_w(IDX_ANALOG_SEL_B, 4'h0);
      bus_w(IDX_DIR_BASE, 4'hF);
      bus_w(IDX_LATCH_BASE, 4'h0);
      bus_w(IDX_PORT_MODE_A, 4'h7);
      bus_w(IDX_SERIAL_MODE, 4'h8);
      settle();
      chk("p0 oe_n", 16'h0003, {12'h0, pin_oe_n[3:0]});
      chk("p0 out", 16'h0003, {14'h0, pin_out[3:2]});
      chk("sck_in", 16'h0000, {15'h0, sck_in});
      chk("si", 16'h0000, {15'h0, serial_in_data});
      bus_r(IDX_PIN_DRIVE);
      chk("drive", 16'h000C, rd[15:0]);
      bus_r(IDX_PIN_LEVEL);
      chk("level", 16'h000C, rd[15:0]);
      bus_w(IDX_EXTRA_CTRL, 4'h4);
      settle();
      chk("p0 oe_n", 16'h0007, {12'h0, pin_oe_n[3:0]});
      @(posedge clk_sys);
      serial_out_data <= 1'b0;
      settle();
      chk("p0 oe_n", 16'h0003, {12'h0, pin_oe_n[3:0]});
      chk("so", 16'h0000, {15'h0, pin_out[2]});
      bus_w(IDX_PORT_MODE_A, 4'h0);
      bus_w(IDX_SERIAL_MODE, 4'h0);
      settle();
      chk("p0 oe_n", 16'h0000, {12'h0, pin_oe_n[3:0]});
      chk("p0 out", 16'h0000, {12'h0, pin_out[3:0]});
      chk("sck_in", 16'h0001, {15'h0, sck_in});
      chk("si", 16'h0001, {15'h0, serial_in_data});
      test_done();
   end
endmodule
